//--- src/ppapd_top.sv
// Purpose: Six-pin port configuration: analog select, weak pull-ups, open-drain drive
// Assumes: AXI4-Lite register access; pad inputs synchronous to clk
// Notes:   All outputs registered
// Functional notes
// - Analog select set disables the pin's digital input buffer; clear gives digital use.
// - Analog select bits reset to one on every reset.
// - Bits 7-6, and bit 3 of analog and open-drain registers, read zero.
// - Pull-up bit one enables that pin's weak pull-up; zero disables it.
// - External reset enabled forces shared reset pin pull-up; stored bit unchanged.
// - Output pins other than the reset pin lose pull-up unless open-drain.
// - Open-drain output pull-up follows driven output value, except on the reset pin.
// - Open-drain bit one sinks only; zero drives push-pull.
// - Analog pins read zero digitally; outputs unaffected.
// - Reset pin pull-up on when reset function or its pull-up bit set.
//
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
module ppapd_top (
	input  wire logic                           clk,
	input  wire logic                           reset,
	input  wire logic [ppapd_pkg::AW-1:0]       s_axi_awaddr,
	input  wire logic                           s_axi_awvalid,
	output logic                                s_axi_awready,
	input  wire logic [ppapd_pkg::DW-1:0]       s_axi_wdata,
	input  wire logic [3:0]                     s_axi_wstrb,
	input  wire logic                           s_axi_wvalid,
	output logic                                s_axi_wready,
	output logic [1:0]                          s_axi_bresp,
	output logic                                s_axi_bvalid,
	input  wire logic                           s_axi_bready,
	input  wire logic [ppapd_pkg::AW-1:0]       s_axi_araddr,
	input  wire logic                           s_axi_arvalid,
	output logic                                s_axi_arready,
	output logic [ppapd_pkg::DW-1:0]            s_axi_rdata,
	output logic [1:0]                          s_axi_rresp,
	output logic                                s_axi_rvalid,
	input  wire logic                           s_axi_rready,
	input  wire logic [ppapd_pkg::NPINS-1:0]    direction_input_bit,
	input  wire logic [ppapd_pkg::NPINS-1:0]    out_value,
	input  wire logic [ppapd_pkg::NPINS-1:0]    pad_in,
	input  wire logic                           external_reset_pin_enable,
	output logic      [ppapd_pkg::NPINS-1:0]    pin_read,
	output logic      [ppapd_pkg::NPINS-1:0]    input_buffer_en,
	output logic      [ppapd_pkg::NPINS-1:0]    pullup_on,
	output logic      [ppapd_pkg::NPINS-1:0]    pad_out,
	output logic      [ppapd_pkg::NPINS-1:0]    pad_oe_n
);
	import ppapd_pkg::*;

	typedef struct packed {
		logic [RW-1:0]   ansel;
		logic [RW-1:0]   wpu;
		logic [RW-1:0]   odc;
		logic            aw_got;
		logic [AW-1:0]   aw_addr;
		logic            w_got;
		logic [RW-1:0]   w_data;
		logic            w_strb0;
		logic            awready;
		logic            wready;
		logic            bvalid;
		logic [1:0]      bresp;
		logic            arready;
		logic            rvalid;
		logic [DW-1:0]   rdata;
		logic [1:0]      rresp;
	} ppapd_regs_s;

	ppapd_regs_s st_ff;
	ppapd_regs_s nxt_st;

	// ==========================================================
	// Address decode shared by read and write paths
	function automatic logic addr_hit(input logic [AW-1:0] a);
		return (a == OFF_ANSEL) || (a == OFF_WPU) || (a == OFF_ODC);
	endfunction

	function automatic logic [DW-1:0] read_word(input logic [AW-1:0] a, input ppapd_regs_s s);
		logic [RW-1:0] v;
		v = '0;
		unique case (a)
			OFF_ANSEL: v = s.ansel & MASK_ANSEL;
			OFF_WPU:   v = s.wpu & MASK_WPU;
			OFF_ODC:   v = s.odc & MASK_ODC;
			default:   v = '0;
		endcase
		return {{(DW-RW){1'b0}}, v};
	endfunction

	// ==========================================================
	// AXI4-Lite slave
	always_comb begin
		nxt_st = st_ff;
		// Address and data may arrive in either order; each is latched once
		if (s_axi_awvalid && st_ff.awready) begin
			nxt_st.aw_got  = 1'b1;
			nxt_st.aw_addr = s_axi_awaddr;
			nxt_st.awready = 1'b0;
		end
		if (s_axi_wvalid && st_ff.wready) begin
			nxt_st.w_got   = 1'b1;
			nxt_st.w_data  = s_axi_wdata[RW-1:0];
			nxt_st.w_strb0 = s_axi_wstrb[0];
			nxt_st.wready  = 1'b0;
		end
		if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid) begin
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp  = addr_hit(st_ff.aw_addr) ? RESP_OKAY : RESP_SLVERR;
			if (st_ff.w_strb0) begin
				unique case (st_ff.aw_addr)
					OFF_ANSEL: nxt_st.ansel = st_ff.w_data & MASK_ANSEL;
					// Reset pin bit stored as written, even when forced on
					OFF_WPU:   nxt_st.wpu = st_ff.w_data & MASK_WPU;
					OFF_ODC:   nxt_st.odc = st_ff.w_data & MASK_ODC;
					default:   nxt_st.bresp = RESP_SLVERR;
				endcase
			end
		end
		if (st_ff.bvalid && s_axi_bready) begin
			nxt_st.bvalid  = 1'b0;
			nxt_st.aw_got  = 1'b0;
			nxt_st.w_got   = 1'b0;
			nxt_st.awready = 1'b1;
			nxt_st.wready  = 1'b1;
		end
		if (s_axi_arvalid && st_ff.arready) begin
			nxt_st.arready = 1'b0;
			nxt_st.rvalid  = 1'b1;
			nxt_st.rdata   = read_word(s_axi_araddr, st_ff);
			nxt_st.rresp   = addr_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end
		if (st_ff.rvalid && s_axi_rready) begin
			nxt_st.rvalid  = 1'b0;
			nxt_st.arready = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			st_ff         <= '0;
			st_ff.ansel   <= RST_ANSEL;
			st_ff.wpu     <= RST_WPU;
			st_ff.odc     <= RST_ODC;
			st_ff.awready <= 1'b1;
			st_ff.wready  <= 1'b1;
			st_ff.arready <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign s_axi_awready = st_ff.awready;
	assign s_axi_wready  = st_ff.wready;
	assign s_axi_bvalid  = st_ff.bvalid;
	assign s_axi_bresp   = st_ff.bresp;
	assign s_axi_arready = st_ff.arready;
	assign s_axi_rvalid  = st_ff.rvalid;
	assign s_axi_rdata   = st_ff.rdata;
	assign s_axi_rresp   = st_ff.rresp;

	// ==========================================================
	// Pad logic; analog pins still drive when set as outputs
	ppapd_pin_cfg u_pins (
		.clk                       (clk),
		.reset                     (reset),
		.analog_select_bit         (st_ff.ansel[NPINS-1:0]),
		.pullup_enable_bit         (st_ff.wpu[NPINS-1:0]),
		.open_drain_enable_bit     (st_ff.odc[NPINS-1:0]),
		.direction_input_bit       (direction_input_bit),
		.out_value                 (out_value),
		.pad_in                    (pad_in),
		.external_reset_pin_enable (external_reset_pin_enable),
		.pin_read                  (pin_read),
		.input_buffer_en           (input_buffer_en),
		.pullup_on                 (pullup_on),
		.pad_out                   (pad_out),
		.pad_oe_n                  (pad_oe_n)
	);

	// ==========================================================
	// Checks
	sequence s_write_done;
		st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;
	endsequence

	sequence s_read_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence

	a_reset_ansel: assert property (@(posedge clk)
		$fell(reset) |-> st_ff.ansel == RST_ANSEL)
		else $error("analog select reset value wrong");
	a_reset_zeroed: assert property (@(posedge clk)
		$fell(reset) |-> (st_ff.wpu == RST_WPU) && (st_ff.odc == RST_ODC))
		else $error("pull-up or open-drain not cleared");
	a_reserved_zero: assert property (@(posedge clk) disable iff (reset)
		s_axi_rvalid |-> s_axi_rdata[RW-1:NPINS] == '0)
		else $error("reserved bits read nonzero");
	a_unimpl_zero: assert property (@(posedge clk) disable iff (reset)
		(st_ff.ansel & ~MASK_ANSEL) == '0 && (st_ff.odc & ~MASK_ODC) == '0 && (st_ff.wpu & ~MASK_WPU) == '0)
		else $error("unimplemented bit stored");
	a_rdata_upper: assert property (@(posedge clk) disable iff (reset)
		s_axi_rvalid |-> s_axi_rdata[DW-1:RW] == '0)
		else $error("read data above byte nonzero");
	a_read_unmapped: assert property (@(posedge clk) disable iff (reset)
		(s_read_taken ##0 !addr_hit(s_axi_araddr)) |=> (s_axi_rresp == RESP_SLVERR) && (s_axi_rdata == '0))
		else $error("unmapped read not refused");
	a_read_ansel: assert property (@(posedge clk) disable iff (reset)
		(s_read_taken ##0 (s_axi_araddr == OFF_ANSEL)) |=> s_axi_rdata[RW-1:0] == $past(st_ff.ansel))
		else $error("analog select read wrong");
	a_read_wpu: assert property (@(posedge clk) disable iff (reset)
		(s_read_taken ##0 (s_axi_araddr == OFF_WPU)) |=> s_axi_rdata[RW-1:0] == $past(st_ff.wpu))
		else $error("pull-up read wrong");
	a_wpu_kept: assert property (@(posedge clk) disable iff (reset)
		(s_write_done ##0 (st_ff.aw_addr != OFF_WPU)) |=> st_ff.wpu == $past(st_ff.wpu))
		else $error("pull-up bits changed by other write");
	a_wpu_stored: assert property (@(posedge clk) disable iff (reset)
		(s_write_done ##0 (st_ff.w_strb0 && st_ff.aw_addr == OFF_WPU)) |=> st_ff.wpu == $past(st_ff.w_data & MASK_WPU))
		else $error("pull-up write not stored");
	a_write_resp: assert property (@(posedge clk) disable iff (reset)
		s_write_done |=> s_axi_bvalid)
		else $error("no write response");
endmodule

//--- src/ppapd_pkg.sv
// Purpose: Constants for the port pin analog, pull-up and drive configuration block
// Assumes: AXI4-Lite slave with 32-bit data, one aligned word per register
// Notes:   Register offsets are byte addresses
package ppapd_pkg;
	// ==========================================================
	// Widths
	localparam int          NPINS      = 6;
	localparam int          AW         = 4;
	localparam int          DW         = 32;
	localparam int          RW         = 8;
	localparam int          RST_PIN    = 3;
	// ==========================================================
	// Register map
	localparam logic [AW-1:0] OFF_ANSEL = 4'h0;
	localparam logic [AW-1:0] OFF_WPU   = 4'h4;
	localparam logic [AW-1:0] OFF_ODC   = 4'h8;
	// ==========================================================
	// Implemented bit masks and reset values
	localparam logic [RW-1:0] MASK_ANSEL = 8'h37;
	localparam logic [RW-1:0] MASK_WPU   = 8'h3f;
	localparam logic [RW-1:0] MASK_ODC   = 8'h37;
	localparam logic [RW-1:0] RST_ANSEL  = 8'h37;
	localparam logic [RW-1:0] RST_WPU    = 8'h00;
	localparam logic [RW-1:0] RST_ODC    = 8'h00;
	// ==========================================================
	// AXI responses
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage

//--- src/ppapd_pin_cfg.sv
// Purpose: Per-pin pad control: input gating, pull-up and drive mode
// Assumes: Inputs are synchronous; outputs registered for clean pad control
// Notes:   One instance covers all six pins
`timescale 1ns/1ps
module ppapd_pin_cfg (
	input  wire logic                          clk,
	input  wire logic                          reset,
	input  wire logic [ppapd_pkg::NPINS-1:0]   analog_select_bit,
	input  wire logic [ppapd_pkg::NPINS-1:0]   pullup_enable_bit,
	input  wire logic [ppapd_pkg::NPINS-1:0]   open_drain_enable_bit,
	input  wire logic [ppapd_pkg::NPINS-1:0]   direction_input_bit,
	input  wire logic [ppapd_pkg::NPINS-1:0]   out_value,
	input  wire logic [ppapd_pkg::NPINS-1:0]   pad_in,
	input  wire logic                          external_reset_pin_enable,
	output logic      [ppapd_pkg::NPINS-1:0]   pin_read,
	output logic      [ppapd_pkg::NPINS-1:0]   input_buffer_en,
	output logic      [ppapd_pkg::NPINS-1:0]   pullup_on,
	output logic      [ppapd_pkg::NPINS-1:0]   pad_out,
	output logic      [ppapd_pkg::NPINS-1:0]   pad_oe_n
);
	import ppapd_pkg::*;

	typedef struct packed {
		logic [NPINS-1:0] rd;
		logic [NPINS-1:0] ibuf;
		logic [NPINS-1:0] pu;
		logic [NPINS-1:0] po;
		logic [NPINS-1:0] oe_n;
	} ppapd_pin_s;

	ppapd_pin_s st_ff;
	ppapd_pin_s nxt_st;

	// ==========================================================
	// Pad decisions
	always_comb begin
		nxt_st = st_ff;
		for (int i = 0; i < NPINS; i++) begin
			nxt_st.ibuf[i] = ~analog_select_bit[i];
			nxt_st.rd[i]   = analog_select_bit[i] ? 1'b0 : pad_in[i];
			if (!direction_input_bit[i] && !open_drain_enable_bit[i]) begin
				nxt_st.pu[i] = 1'b0;
			end else if (!direction_input_bit[i]) begin
				nxt_st.pu[i] = out_value[i];
			end else begin
				nxt_st.pu[i] = pullup_enable_bit[i];
			end
			// Output path ignores analog mode, as digital drivers stay live
			if (direction_input_bit[i]) begin
				nxt_st.po[i]   = 1'b0;
				nxt_st.oe_n[i] = 1'b1;
			end else if (open_drain_enable_bit[i]) begin
				nxt_st.po[i]   = 1'b0;
				nxt_st.oe_n[i] = out_value[i];
			end else begin
				nxt_st.po[i]   = out_value[i];
				nxt_st.oe_n[i] = 1'b0;
			end
		end
		// Shared reset pin pull-up ignores direction; it is on when the reset function or its pull-up bit is set
		nxt_st.pu[RST_PIN] = external_reset_pin_enable | pullup_enable_bit[RST_PIN];
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			st_ff <= '{rd: '0, ibuf: '0, pu: '0, po: '0, oe_n: '1};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign pin_read        = st_ff.rd;
	assign input_buffer_en = st_ff.ibuf;
	assign pullup_on       = st_ff.pu;
	assign pad_out         = st_ff.po;
	assign pad_oe_n        = st_ff.oe_n;

	// ==========================================================
	// Checks
	a_analog_reads_zero: assert property (@(posedge clk) disable iff (reset)
		analog_select_bit[0] |=> (pin_read[0] == 1'b0) && !input_buffer_en[0])
		else $error("analog pin read not zero");
	a_rst_pin_pullup: assert property (@(posedge clk) disable iff (reset)
		external_reset_pin_enable |=> pullup_on[RST_PIN])
		else $error("reset pin pull-up off");
	a_rst_pin_off: assert property (@(posedge clk) disable iff (reset)
		(!external_reset_pin_enable && !pullup_enable_bit[RST_PIN]) |=> !pullup_on[RST_PIN])
		else $error("reset pin pull-up on");
	a_output_pullup_off: assert property (@(posedge clk) disable iff (reset)
		(!direction_input_bit[0] && !open_drain_enable_bit[0]) |=> !pullup_on[0])
		else $error("push-pull output pull-up on");
	a_od_pullup_follow: assert property (@(posedge clk) disable iff (reset)
		(!direction_input_bit[1] && open_drain_enable_bit[1]) |=> pullup_on[1] == $past(out_value[1]))
		else $error("open-drain pull-up wrong");
	a_od_never_source: assert property (@(posedge clk) disable iff (reset)
		open_drain_enable_bit[2] |=> !(pad_out[2] && !pad_oe_n[2]))
		else $error("open-drain sourced high");
	a_input_pullup_bit: assert property (@(posedge clk) disable iff (reset)
		direction_input_bit[4] |=> pullup_on[4] == $past(pullup_enable_bit[4]))
		else $error("input pull-up mismatch");
endmodule

//--- sim/ppapd_pad_model.sv
// Purpose: Pad and external source model for the six port pins
// Assumes: Design pad outputs change just after the rising edge
// Notes:   A floating pin without pull-up inverts every cycle
`timescale 1ns/1ps
module ppapd_pad_model (
	input  wire logic                        clk,
	input  wire logic [ppapd_pkg::NPINS-1:0] pad_out,
	input  wire logic [ppapd_pkg::NPINS-1:0] pad_oe_n,
	input  wire logic [ppapd_pkg::NPINS-1:0] pullup_on,
	output logic      [ppapd_pkg::NPINS-1:0] pad_in
);
	import ppapd_pkg::*;
	logic [NPINS-1:0] src_ff = 6'h15;
	// ==========================================================
	// External source
	// Moving level, so a stale or guessed read cannot match
	always @(posedge clk) src_ff <= ~src_ff;
	// ==========================================================
	// Wire level
	always_comb begin
		for (int i = 0; i < NPINS; i++) begin
			if (!pad_oe_n[i]) pad_in[i] = pad_out[i];
			else if (pullup_on[i]) pad_in[i] = 1'b1;
			else pad_in[i] = src_ff[i];
		end
	end
endmodule

//--- sim/tb_top.sv
// Purpose: Self-checking bench for the port pin configuration block
// Assumes: AXI4-Lite master tasks; pad model on the far side
// Notes:   Random configurations from a fixed seed
`timescale 1ns/1ps
module tb_top;
	import ppapd_pkg::*;
	logic             clk = 0, reset = 1, ext = 0;
	logic [AW-1:0]    awaddr = '0, araddr = '0;
	logic             awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic             awready, wready, bvalid, arready, rvalid;
	logic [DW-1:0]    wdata = '0, rdata, rdv;
	logic [3:0]       wstrb = '0;
	logic [1:0]       bresp, rresp, rsp;
	logic [NPINS-1:0] dir = '1, outv = '0, pad_in, pin_read, ibuf, pu, pad_out, oe_n;
	logic [RW-1:0]    m [0:3];
	int               num_errors = 0, n_compared = 0, k;
	always #25 clk = ~clk;
	// ==========================================================
	// Design and pads
	ppapd_top i_ppapd_top (.clk(clk), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .direction_input_bit(dir),
		.out_value(outv), .pad_in(pad_in), .external_reset_pin_enable(ext), .pin_read(pin_read),
		.input_buffer_en(ibuf), .pullup_on(pu), .pad_out(pad_out), .pad_oe_n(oe_n));
	ppapd_pad_model i_ppapd_pad_model (.clk(clk), .pad_out(pad_out),
		.pad_oe_n(oe_n), .pullup_on(pu), .pad_in(pad_in));
	// ==========================================================
	// Expectations
	function automatic logic ok_addr(input logic [AW-1:0] a);
		return a[1:0] == 2'h0 && a[3:2] != 2'h3;
	endfunction
	function automatic logic [1:0] eresp(input logic [AW-1:0] a);
		return ok_addr(a) ? 2'h0 : 2'h2;
	endfunction
	function automatic logic [DW-1:0] erd(input logic [AW-1:0] a);
		return ok_addr(a) ? {24'h0000_00, m[a[3:2]]} : 32'h0000_0000;
	endfunction
	// ==========================================================
	// Compare and bus tasks
	task automatic chk_w(input string n, input logic [DW-1:0] e, input logic [DW-1:0] g);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk_p(input string n, input logic [5:0] e, input logic [5:0] g, input logic [5:0] msk);
		chk_w(n, {26'h0, e & msk}, {26'h0, g & msk});
	endtask
	task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d, input logic [3:0] s);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
		end while (!(bvalid && bready));
		rsp = bresp;
		bready <= 0;
	endtask
	task automatic rchk(input logic [AW-1:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 0;
		end while (!(rvalid && rready));
		rdv = rdata;
		rsp = rresp;
		rready <= 0;
		chk_w("rdata", erd(a), rdv);
		chk_w("rresp", {30'h0, eresp(a)}, {30'h0, rsp});
	endtask
	task automatic wreg(input logic [AW-1:0] a, input logic [DW-1:0] d, input logic [3:0] s);
		wr(a, d, s);
		chk_w("bresp", {30'h0, eresp(a)}, {30'h0, rsp});
		if (ok_addr(a) && s[0]) m[a[3:2]] = d[7:0] & (a[3:2] == 2'h1 ? 8'h3f : 8'h37);
		rchk(a);
	endtask
	task automatic pads();
		logic [NPINS-1:0] seen, eu;
		repeat (3) @(posedge clk);
		@(negedge clk);
		seen = pad_in;
		@(negedge clk);
		for (int i = 0; i < NPINS; i++) eu[i] = dir[i] ? m[1][i] : m[2][i] & outv[i];
		eu[3] = ext | m[1][3];
		chk_p("input_buffer_en", ~m[0][5:0], ibuf, 6'h3f);
		chk_p("pin_read", seen & ~m[0][5:0], pin_read, 6'h3f);
		chk_p("pullup_on", eu, pu, 6'h3f);
		chk_p("pad_out", outv & ~m[2][5:0] & ~dir, pad_out, 6'h3f);
		chk_p("pad_oe_n", dir | (outv & m[2][5:0]), oe_n, 6'h3f);
	endtask
	task automatic do_reset();
		@(posedge clk);
		reset <= 1;
		repeat (16) @(posedge clk);
		reset <= 0;
		m = '{8'h37, 8'h00, 8'h00, 8'h00};
	endtask
	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// ==========================================================
	// Tests
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		tally_and_finish();
	end
	initial begin
		void'($urandom(32'hc890_bd37));
		for (k = 0; k < 2; k++) begin
			do_reset();
			rchk(OFF_ANSEL);
			rchk(OFF_WPU);
			rchk(OFF_ODC);
			pads();
			$display("test reset_values done");
			wreg(OFF_WPU, 32'hffff_ffff, 4'h0);
			wreg(4'hc, 32'hffff_ffff, 4'h1);
			for (int a = 0; a < 12; a += 4) wreg(AW'(a), 32'hffff_ffff, 4'h1);
			$display("test reserved_bits done");
			for (int j = 0; j < 30; j++) begin
				for (int a = 0; a < 12; a += 4) wreg(AW'(a), $urandom, 4'h1);
				@(posedge clk);
				dir <= NPINS'($urandom) | (j[0] ? 6'h00 : m[0][5:0]) | 6'h08;
				outv <= NPINS'($urandom);
				ext <= 1'($urandom);
				pads();
			end
			$display("test random_pads done");
		end
		tally_and_finish();
	end
endmodule
